// *** timer_pkg.sv ***
// constants for the eight-bit timer / event counter
// assumes a single 50 MHz clock and a plain strobe register port
// Operation
// RULE1: timer and pulse modes use divided clock
// RULE2: prescaler ignored when pin clocks counter
// RULE3: event mode counts rising or falling edges
// RULE4: count to FF, overflow reloads and interrupts
// RULE5: stopped preload write also loads count
// RULE6: running preload write waits for overflow
// RULE7: mode chosen by control bits 7:6
// RULE8: control bit 4 runs or stops counter
// RULE9: pulse mode run bit only arms
// RULE10: polarity 0: falling starts, rising stops
// RULE11: polarity 1: rising starts, falling stops
// RULE12: run bit self-clears only in pulse mode
// RULE13: after pulse stop, pin edges ignored
// RULE14: residual count readable after pulse stop
// RULE15: pulse mode reacts to edges, not levels
// RULE16: interrupt output gated by enable bit
// RULE17: event counting continues during power down
// RULE18: software makes count pin an input
// RULE19: software loads zero for full range
// RULE20: preload has no reset value
// RULE21: overflow sets request flag always
// RULE22: count read or preload write inhibits clock
// RULE23: pin events seen at next timer tick
// RULE24: modes: 00 off, 01 event, 10 timer, 11 pulse
// RULE25: divider n gives ratio two to n plus one
package timer_pkg;
  localparam logic [1:0] ADDR_COUNT       = 2'h0;
  localparam logic [1:0] ADDR_CONFIG      = 2'h1;
  localparam logic [1:0] ADDR_IRQ_CTRL    = 2'h2;
  localparam int         DIV_LSB          = 0;
  localparam int         EDGE_BIT         = 3;
  localparam int         RUN_BIT          = 4;
  localparam int         MODE_LSB         = 6;
  localparam int         IRQ_EN_BIT       = 0;
  localparam int         IRQ_FLAG_BIT     = 1;
  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic [7:0] COUNT_RESET      = 8'h00;
  localparam logic [7:0] COUNT_FULL       = 8'hFF;
  localparam int         PRESCALE_BITS    = 8;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_EVENT,
    MODE_TIMER,
    MODE_PULSE
  } mode_t;
endpackage : timer_pkg

// *** count_timer.sv ***
// eight-bit up counter with preload, timer, event and pulse width modes
// assumes count_pin is asynchronous and the bus master never waits
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module count_timer
  import timer_pkg::*;
#(
  parameter int DIV_WIDTH = PRESCALE_BITS
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic       count_pin,
  input  wire logic       power_down,
  output logic      [7:0] rdata,
  output logic            irq,
  output logic            wake
);
  typedef struct packed {
    logic [2:0]               pin_sync;
    logic                     pin_level;
    logic                     pin_event;
    logic [DIV_WIDTH-1:0]     prescale;
    logic [7:0]               count;
    logic [7:0]               preload;
    logic [7:0]               config_byte;
    logic                     pulse_active;
    logic                     irq_en;
    logic                     irq_flag;
    logic [7:0]               rdata;
    logic                     irq;
    logic                     wake;
  } state_t;

  state_t s_q;
  state_t s_d;

  // the divider taps need eight stages for the longest ratio
  if (DIV_WIDTH < 8)
  begin : g_div_width_check
    $error("count_timer: DIV_WIDTH below 8 cannot reach the longest ratio");
  end

  // every control field must sit inside the control byte
  if (MODE_LSB > 6 || RUN_BIT > 7 || EDGE_BIT > 7 || DIV_LSB > 5)
  begin : g_field_check
    $error("count_timer: control field outside the byte");
  end

  // the two interrupt control bits must not share a position
  if (IRQ_EN_BIT == IRQ_FLAG_BIT || IRQ_EN_BIT > 7 || IRQ_FLAG_BIT > 7)
  begin : g_irq_field_check
    $error("count_timer: interrupt control fields overlap");
  end

  // three distinct register indices
  if (ADDR_COUNT == ADDR_CONFIG || ADDR_COUNT == ADDR_IRQ_CTRL || ADDR_CONFIG == ADDR_IRQ_CTRL)
  begin : g_addr_check
    $error("count_timer: register indices collide");
  end

  // divider tap: ratio two to the power sel plus one
  function automatic logic div_tick(
    input logic [2:0] sel,
    input logic [7:0] pre
  );
    logic [7:0] mask;
    mask     = 8'hFF >> (3'h7 - sel);
    div_tick = (pre & mask) == mask; // RULE25
  endfunction : div_tick

  // true when one strobe targets one register index
  function automatic logic reg_hit(
    input logic       strobe,
    input logic [1:0] a,
    input logic [1:0] idx
  );
    reg_hit = strobe && (a == idx);
  endfunction : reg_hit

  // polarity 0 picks the rising edge, polarity 1 the falling one
  function automatic logic pick_edge(
    input logic pol,
    input logic r,
    input logic f
  );
    pick_edge = pol ? f : r;
  endfunction : pick_edge

  // mode field of a control byte
  function automatic mode_t mode_of(input logic [7:0] cfg);
    mode_of = mode_t'(cfg[MODE_LSB +: 2]); // RULE7 RULE24
  endfunction : mode_of

  // a pin change counts only once the last two stages agree
  function automatic logic sync_level(
    input logic [2:0] stages,
    input logic       held
  );
    if (stages[2] == stages[1])
    begin
      sync_level = stages[2];
    end
    else
    begin
      sync_level = held;
    end
  endfunction : sync_level

  // one count step: plus one, or the preload once the count is full
  function automatic logic [7:0] bump(
    input logic [7:0] cur,
    input logic [7:0] pre
  );
    if (cur == COUNT_FULL)
    begin
      bump = pre; // RULE4 RULE6
    end
    else
    begin
      bump = cur + 8'h01;
    end
  endfunction : bump

  // count after one cycle: a stopped preload write wins over a step
  function automatic logic [7:0] count_next(
    input logic       stepping,
    input logic       load_now,
    input logic [7:0] cur,
    input logic [7:0] pre,
    input logic [7:0] data
  );
    if (load_now)
    begin
      count_next = data; // RULE5
    end
    else if (stepping)
    begin
      count_next = bump(cur, pre);
    end
    else
    begin
      count_next = cur;
    end
  endfunction : count_next

  // interrupt line: flag gated by enable; the flag itself is never gated
  function automatic logic irq_line(
    input logic flag,
    input logic en
  );
    irq_line = flag && en; // RULE16
  endfunction : irq_line

  // read multiplexer; the unmapped index reads as zero
  function automatic logic [7:0] read_mux(
    input logic [1:0] a,
    input logic [7:0] cnt,
    input logic [7:0] cfg,
    input logic       ien,
    input logic       iflag
  );
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_COUNT:
      begin
        r = cnt; // RULE14
      end
      ADDR_CONFIG:
      begin
        r = cfg;
      end
      ADDR_IRQ_CTRL:
      begin
        r[IRQ_EN_BIT]   = ien;
        r[IRQ_FLAG_BIT] = iflag;
      end
      default:
      begin
        r = 8'h00;
      end
    endcase
    read_mux = r;
  endfunction : read_mux

  mode_t      mode;
  logic       edge_pol;
  logic       run;
  logic [2:0] div_sel;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       start_edge;
  logic       stop_edge;
  logic       expect_edge;
  logic       pending;
  logic       count_rd;
  logic       pre_wr;
  logic       cfg_wr;
  logic       irq_wr;
  logic       inhibit;
  logic       step;
  logic       ovf;

  always_comb
  begin
    s_d      = s_q;
    pending  = 1'b0;
    mode     = mode_of(s_q.config_byte); // RULE7 RULE24
    edge_pol = s_q.config_byte[EDGE_BIT];
    run      = s_q.config_byte[RUN_BIT]; // RULE8
    div_sel  = s_q.config_byte[DIV_LSB +: 3];

    // pin: three stages, level taken once the last two agree
    s_d.pin_sync  = {s_q.pin_sync[1:0], count_pin};
    s_d.pin_level = sync_level(s_q.pin_sync, s_q.pin_level);
    rise          = s_d.pin_level & ~s_q.pin_level;
    fall          = ~s_d.pin_level & s_q.pin_level;

    // free-running divider; only the tap depends on the divider field
    s_d.prescale = s_q.prescale + 1'b1; // RULE1
    tick         = div_tick(div_sel, s_q.prescale[7:0]); // RULE25

    // edges count, not levels
    start_edge  = pick_edge(~edge_pol, rise, fall); // RULE10 RULE11
    stop_edge   = pick_edge(edge_pol, rise, fall); // RULE15
    expect_edge = (s_q.pulse_active ^ s_q.pin_event) ? stop_edge : start_edge;

    // register strobes
    count_rd = reg_hit(rd, addr, ADDR_COUNT);
    pre_wr   = reg_hit(wr, addr, ADDR_COUNT);
    cfg_wr   = reg_hit(wr, addr, ADDR_CONFIG);
    irq_wr   = reg_hit(wr, addr, ADDR_IRQ_CTRL);
    // any count access stalls the counter that cycle; counts may be lost
    inhibit  = count_rd || pre_wr; // RULE22

    step          = 1'b0;
    s_d.pin_event = 1'b0;
    case (mode)
      MODE_EVENT:
      begin
        // pin clocks the counter, divider unused; power down has no say
        step = run && pick_edge(edge_pol, rise, fall); // RULE2 RULE3 RULE17
      end
      MODE_TIMER:
      begin
        step = run && tick; // RULE1
      end
      MODE_PULSE:
      begin
        if (!run)
        begin
          // disarmed: edges dropped until software sets run again
          s_d.pulse_active = 1'b0; // RULE13
          s_d.pin_event    = 1'b0;
        end
        else
        begin
          // an edge waits for the next timer tick; a pulse shorter
          // than one tick cancels itself and leaves the counter armed
          pending = s_q.pin_event ^ expect_edge; // RULE23
          if (tick && pending)
          begin
            s_d.pin_event = 1'b0;
            if (!s_q.pulse_active)
            begin
              s_d.pulse_active = 1'b1; // RULE9
            end
            else
            begin
              s_d.pulse_active         = 1'b0;
              s_d.config_byte[RUN_BIT] = 1'b0; // RULE10 RULE11 RULE12 RULE14
            end
          end
          else
          begin
            s_d.pin_event = pending && !tick;
          end
        end
        step = run && s_q.pulse_active && tick; // RULE1
      end
      default:
      begin
        step = 1'b0;
      end
    endcase

    if (inhibit)
    begin
      step = 1'b0; // RULE22
    end
    ovf = step && (s_q.count == COUNT_FULL);

    // preload write; a stopped counter takes it at once
    if (pre_wr)
    begin
      s_d.preload = wdata;
    end
    s_d.count = count_next(step, pre_wr && !run, s_q.count, s_q.preload, wdata); // RULE5 RULE6

    // a config write overrides the self-clear of the same cycle
    if (cfg_wr)
    begin
      s_d.config_byte = wdata; // RULE8 RULE12
      if (mode_of(wdata) != MODE_PULSE || !wdata[RUN_BIT])
      begin
        s_d.pulse_active = 1'b0;
      end
      s_d.pin_event = 1'b0;
    end

    if (irq_wr)
    begin
      s_d.irq_en   = wdata[IRQ_EN_BIT];
      s_d.irq_flag = wdata[IRQ_FLAG_BIT];
    end
    // an overflow in the cycle of a flag write wins
    if (ovf)
    begin
      s_d.irq_flag = 1'b1; // RULE21
    end

    s_d.rdata = 8'h00;
    if (rd)
    begin
      s_d.rdata = read_mux(addr, s_q.count, s_q.config_byte, // RULE14
                           s_q.irq_en, s_q.irq_flag);
    end

    s_d.irq  = irq_line(s_d.irq_flag, s_d.irq_en); // RULE16
    // wake pulses on overflow during power down, whatever the enable says
    s_d.wake = ovf && power_down; // RULE17
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // preload keeps whatever it held: no defined reset value
      s_q.pin_sync     <= 3'h0;
      s_q.pin_level    <= 1'b0;
      s_q.pin_event    <= 1'b0;
      s_q.prescale     <= '0;
      s_q.count        <= COUNT_RESET;
      s_q.preload      <= s_d.preload; // RULE20
      s_q.config_byte  <= CONFIG_RESET;
      s_q.pulse_active <= 1'b0;
      s_q.irq_en       <= 1'b0;
      s_q.irq_flag     <= 1'b0;
      s_q.rdata        <= 8'h00;
      s_q.irq          <= 1'b0;
      s_q.wake         <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign irq   = s_q.irq;
  assign wake  = s_q.wake;
endmodule : count_timer

// *** timer_asserts.sv ***
// port checker for count_timer
// assumes bind into count_timer, one clock, sync reset
`timescale 1ns/1ps
module timer_asserts (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic       count_pin,
  input wire logic       power_down,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       wake
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata");
  a_unmapped_zero: assert property (rd && addr == 2'h3 |=> rdata == 8'h00) else $error("unmapped");
  a_wake_power: assert property (wake |-> $past(power_down)) else $error("wake");
  a_wake_pulse: assert property (wake |=> !wake) else $error("wake long");
  a_irq_mask: assert property (wr && addr == 2'h2 && !wdata[0] |-> ##2 !irq) else $error("irq");
  a_irq_holds: assert property (irq && !wr && !$past(wr) |=> irq) else $error("irq drop");
  a_config_back: assert property (wr && addr == 2'h1 && wdata[7:6] != 2'h3 ##1 rd && addr == 2'h1
    |=> (rdata & 8'hDF) == ($past(wdata, 2) & 8'hDF)) else $error("config");
  a_stop_load: assert property (wr && addr == 2'h1 && !wdata[4] ##1 wr && addr == 2'h0
    ##1 rd && addr == 2'h0 |=> rdata == $past(wdata, 2)) else $error("load");
  c_irq: cover property (irq);
  c_wake: cover property (wake);
  c_pulse: cover property (rd && addr == 2'h1 ##1 rdata[7:6] == 2'h3);
endmodule : timer_asserts
bind count_timer timer_asserts u_chk (
  .clock      (clock),
  .rst        (rst),
  .addr       (addr),
  .wdata      (wdata),
  .wr         (wr),
  .rd         (rd),
  .count_pin  (count_pin),
  .power_down (power_down),
  .rdata      (rdata),
  .irq        (irq),
  .wake       (wake)
);

// *** count_source.sv ***
// external event or pulse source on the count pin
// assumes the bench calls hold right after a rising edge
`timescale 1ns/1ps
module count_source (
  input  wire logic clock,
  output logic      count_pin
);
  initial count_pin = 1'b0;
  // each level held several cycles so the pin synchroniser settles
  task automatic hold(input logic l, input int n);
    @(posedge clock);
    count_pin <= l;
    repeat (n) @(posedge clock);
  endtask : hold
endmodule : count_source

// *** testbench.sv ***
// bench for count_timer: registers, timer, event and pulse modes
// assumes count_source on the pin and timer_asserts bound in
`timescale 1ns/1ps
module testbench
  import timer_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       power_down = 1'b1;
  logic [7:0] rdata;
  logic       irq;
  logic       wake;
  wire logic  count_pin;
  int         n_mismatch = 0;
  int         checks_done = 0;
  logic [7:0] v;
  logic [7:0] p;
  int         c;
  int         k;
  always #10 clock = ~clock;
  count_timer u_dut (
    .clock      (clock),
    .rst        (rst),
    .addr       (addr),
    .wdata      (wdata),
    .wr         (wr),
    .rd         (rd),
    .count_pin  (count_pin),
    .power_down (power_down),
    .rdata      (rdata),
    .irq        (irq),
    .wake       (wake)
  );
  count_source u_src (
    .clock     (clock),
    .count_pin (count_pin)
  );
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic near(input logic [7:0] g, input logic [7:0] e, input int t);
    checks_done++;
    if ($isunknown(g) || g + t < e || g > e + t)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask : near
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clock);
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] q);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 q = rdata;
  endtask : rd_reg
  task automatic pin(input logic l, input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    u_src.hold(l, n);
  endtask : pin
  task automatic wait_wake(output int n);
    wr <= 1'b0;
    rd <= 1'b0;
    n = 0;
    // step off the current edge so a wake still standing is not counted
    do
    begin
      @(posedge clock) #1;
      n++;
    end
    while (n < 1100 && wake !== 1'b1);
    if (wake !== 1'b1)
    begin
      near(8'h00, 8'h01, 0);
      give_verdict;
    end
  endtask : wait_wake
  function automatic logic [7:0] exp_cnt(input logic [7:0] s, input int n);
    logic [7:0] x;
    x = s;
    repeat (n) x = (x == 8'hFF) ? s : x + 8'h01;
    return x;
  endfunction : exp_cnt
  initial
  begin
    void'($urandom(32'h9BBB));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd_reg(ADDR_COUNT, v);
    near(v, COUNT_RESET, 0);
    rd_reg(ADDR_CONFIG, v);
    near(v, CONFIG_RESET, 0);
    wr_reg(2'h3, 8'hA5);
    rd_reg(2'h3, v);
    near(v, 8'h00, 0);
    repeat (4)
    begin
      p = $urandom;
      wr_reg(ADDR_CONFIG, 8'h00);
      wr_reg(ADDR_COUNT, p);
      rd_reg(ADDR_COUNT, v);
      near(v, p, 0);
    end
    $display("registers done");
    wr_reg(ADDR_IRQ_CTRL, 8'h01);
    for (int n = 0; n < 8; n++)
    begin
      wr_reg(ADDR_COUNT, 8'hFE);
      wr_reg(ADDR_CONFIG, {5'h12, 3'(n)});
      rd_reg(ADDR_CONFIG, v);
      near(v, {5'h12, 3'(n)}, 0);
      wait_wake(c);
      wait_wake(c);
      near(8'(c - (4 << n)), 8'h00, 0);
      near({7'h00, irq}, 8'h01, 0);
      wr_reg(ADDR_CONFIG, 8'h00);
    end
    wr_reg(ADDR_IRQ_CTRL, 8'h00);
    wr_reg(ADDR_CONFIG, 8'h90);
    wait_wake(c);
    near({7'h00, irq}, 8'h00, 0);
    rd_reg(ADDR_IRQ_CTRL, v);
    near(v, 8'h02, 0);
    power_down <= 1'b0;
    k = 0;
    repeat (40)
    begin
      @(posedge clock) #1;
      k += int'(wake !== 1'b0);
    end
    near(8'(k), 8'h00, 0);
    power_down <= 1'b1;
    wr_reg(ADDR_CONFIG, 8'h00);
    $display("timer done");
    for (int e = 0; e < 2; e++)
    begin
      p = $urandom;
      k = $urandom_range(20, 3);
      wr_reg(ADDR_COUNT, p);
      wr_reg(ADDR_CONFIG, {4'h5, e[0], 3'($urandom_range(7))});
      repeat (k)
      begin
        pin(1'b1, $urandom_range(12, 6));
        pin(1'b0, $urandom_range(12, 6));
      end
      pin(1'b1, 8);
      wr_reg(ADDR_CONFIG, 8'h00);
      pin(1'b0, 8);
      rd_reg(ADDR_COUNT, v);
      near(v, exp_cnt(p, k + 1 - e), 0);
      wr_reg(ADDR_COUNT, 8'h00);
      pin(!e[0], 8);
      wr_reg(ADDR_CONFIG, {4'hD, e[0], 3'h0});
      pin(!e[0], 20);
      pin(e[0], 40);
      pin(!e[0], 10);
      pin(e[0], 10);
      pin(!e[0], 10);
      rd_reg(ADDR_CONFIG, v);
      near(v, {4'hC, e[0], 3'h0}, 0);
      rd_reg(ADDR_COUNT, v);
      near(v, 8'h14, 2);
    end
    $display("event and pulse done");
    give_verdict;
  end
endmodule : testbench
